// File: core/acs_pkg.sv
// Purpose: Shared constants for the converter channel sequencer.
// Assumes: One 100 MHz clock; host strobes arrive asynchronously.
// Notes: Mode codes, memory layout and conversion timing live here.
//
// Notes on behaviour
// - Sequence memory holds sixteen entries of address plus input setup.
// - Last-entry flag is produced by the device, never written by host.
// - Each entry reads back as a seven-bit word: six setup bits plus flag.
// - Mode 10 is program/readback: busy low, conversion starts ignored.
// - Any level change on either mode pin clears the pointer to zero.
// - Write strobe rising edge, read strobe high, stores entry and advances.
// - Last entry written before low mode pin rises ends the sequence.
// - After sixteen writes the pointer wraps and new sequence begins.
// - Read strobe low, write strobe high: present entry, enable drivers.
// - Bit six on pair output, five-three on channel out, two-zero on top data.
// - Lower result data pins stay undriven during readback.
// - Read strobe rising edge releases outputs and advances pointer.
// - Bit zero set marks final entry; all sixteen remain readable.
// - After sixteen reads the pointer wraps to zero.
// - Low mode pin rising after programming restores busy high.
// - First run-mode conversion start uses entry zero.
// - Pointer advances per conversion; address outputs show real channel.
// - After the final programmed entry the pointer returns to zero.
// - Sequence contents survive mode changes and deselection.
// - Modes: 00 direct, 01 scan, 10 program/readback, 11 sequence run.
// - Direct and scan modes latch pins on write rise or start fall.
// - Start falling with select low converts; busy low until done.
package acs_pkg;
  localparam int ENTRY_COUNT = 16;
  localparam int PTR_W = 4;
  localparam int CFG_W = 6;
  localparam int WORD_W = 7;
  localparam int DATA_W = 12;
  localparam int LOW_PINS = 9;
  localparam int STAT_HI = 2;
  localparam int CHAN_W = 3;
  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  // Setup word layout: pair, channel[2:0], polarity, gain
  localparam int CFG_PAIR = 5;
  localparam int CFG_CH_HI = 4;
  localparam int CFG_CH_LO = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_GAIN = 0;
  localparam int CONV_TIME_NS = 650;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [2:0] SCAN_STEP_SINGLE = 3'h1;
  localparam logic [2:0] SCAN_STEP_PAIR = 3'h2;

  typedef enum logic [1:0] {
    ACS_MODE_DIRECT = 2'b00,
    ACS_MODE_SCAN = 2'b01,
    ACS_MODE_PROG = 2'b10,
    ACS_MODE_RUN = 2'b11
  } acs_mode_t;
endpackage

// File: core/acs_sequencer.sv
// Purpose: Channel sequencer and conversion control for the converter.
// Assumes: Host pins are asynchronous and pass a two-stage synchroniser.
// Notes: Conversion itself is a timed busy window; result data is an input.
module acs_sequencer #(
  parameter int CONV_CNT = acs_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic pair_select,
  input wire logic [acs_pkg::CHAN_W-1:0] channel_select_bits,
  input wire logic polarity_select,
  input wire logic gain_select,
  input wire logic [acs_pkg::DATA_W-1:0] conv_result,
  output logic busy,
  output logic pair_indicator_out,
  output logic [acs_pkg::CHAN_W-1:0] channel_out_bits,
  output logic polarity_out,
  output logic gain_out,
  output logic conv_start_pulse,
  output logic [acs_pkg::DATA_W-1:0] data_out,
  output logic [acs_pkg::DATA_W-1:0] data_oe,
  output logic addr_oe
);
  import acs_pkg::*;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_meta, rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Bit positions of each pin inside the synchroniser bank
  localparam int NSYNC = 12;
  localparam int IX_MHI = 11;
  localparam int IX_MLO = 10;
  localparam int IX_WR = 9;
  localparam int IX_RD = 8;
  localparam int IX_CV = 7;
  localparam int IX_CS = 6;
  logic [NSYNC-1:0] pin_meta, pin_sync, pin_last;
  wire [NSYNC-1:0] pin_raw = {mode_select_hi, mode_select_lo,
    write_strobe_n, read_strobe_n, convert_start_n, chip_select_n,
    pair_select, channel_select_bits, polarity_select, gain_select};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_last <= '1;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Edges are judged on the synchronised copies only
  wire s_mhi = pin_sync[IX_MHI];
  wire s_mlo = pin_sync[IX_MLO];
  wire s_wr = pin_sync[IX_WR];
  wire s_rd = pin_sync[IX_RD];
  wire s_cs = pin_sync[IX_CS];
  wire [CFG_W-1:0] pin_cfg = pin_sync[CFG_W-1:0];
  wire mode_edge = (pin_sync[IX_MHI] ^ pin_last[IX_MHI])
    | (pin_sync[IX_MLO] ^ pin_last[IX_MLO]);
  wire wr_rise = s_wr & ~pin_last[IX_WR];
  wire rd_fall = ~s_rd & pin_last[IX_RD];
  wire rd_rise = s_rd & ~pin_last[IX_RD];
  wire cv_fall = ~pin_sync[IX_CV] & pin_last[IX_CV];
  wire mlo_rise = s_mlo & ~pin_last[IX_MLO];

  acs_mode_t mode;
  assign mode = acs_mode_t'({s_mhi, s_mlo});
  wire in_prog = (mode == ACS_MODE_PROG);
  wire in_run = (mode == ACS_MODE_RUN);

  // ----------------------------------------
  // Sequence memory
  // ----------------------------------------
  // No reset on contents: they survive mode changes and deselection
  logic [CFG_W-1:0] seq_mem [ENTRY_COUNT];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] last_ptr;
  logic [PTR_W-1:0] wr_last;
  logic wrote_any;

  wire do_write = in_prog & wr_rise & s_rd;
  wire do_read_end = in_prog & rd_rise & s_wr;
  logic busy_conv;
  wire start_ok = cv_fall & ~s_cs & ~busy_conv & ~in_prog;
  wire run_start = start_ok & in_run;

  // Last-entry flag derived from stored end marker
  wire [WORD_W-1:0] cur_word = {seq_mem[ptr],
    ptr == last_ptr};

  always_ff @(posedge clk) begin
    if (do_write) begin
      seq_mem[ptr] <= pin_cfg;
    end
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + PTR_ONE;
  endfunction

  logic [PTR_W-1:0] next_ptr;
  always_comb begin
    next_ptr = ptr;
    if (mode_edge) begin
      next_ptr = PTR_ZERO;
    end else if (do_write || do_read_end) begin
      next_ptr = ptr_inc(ptr);
    end else if (run_start) begin
      next_ptr = (ptr == last_ptr) ? PTR_ZERO
        : ptr_inc(ptr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= PTR_ZERO;
      last_ptr <= PTR_ZERO;
      wr_last <= PTR_ZERO;
      wrote_any <= 1'b0;
    end else begin
      ptr <= next_ptr;
      if (do_write) begin
        wr_last <= ptr;
        wrote_any <= 1'b1;
      end else if (mlo_rise) begin
        wrote_any <= 1'b0;
      end
      // The final write of the pass becomes the end of the sequence
      if (mlo_rise && s_mhi && wrote_any) begin
        last_ptr <= wr_last;
      end
    end
  end

  // ----------------------------------------
  // Conversion timing and channel latch
  // ----------------------------------------
  logic [$clog2(CONV_CNT+1)-1:0] conv_cnt;
  logic [CHAN_W-1:0] scan_addr;
  logic [CFG_W-1:0] held_cfg;
  logic [CFG_W-1:0] conv_cfg;

  wire [CHAN_W-1:0] scan_step = pin_cfg[CFG_PAIR] ? SCAN_STEP_PAIR
    : SCAN_STEP_SINGLE;
  wire latch_pins = (mode == ACS_MODE_DIRECT || mode == ACS_MODE_SCAN)
    & (wr_rise | cv_fall);
  wire [CFG_W-1:0] scan_cfg = {pin_cfg[CFG_PAIR], scan_addr,
    pin_cfg[CFG_POL], pin_cfg[CFG_GAIN]};
  wire [CFG_W-1:0] start_cfg = in_run ? seq_mem[ptr]
    : (mode == ACS_MODE_SCAN) ? scan_cfg
    : (s_wr ? held_cfg : pin_cfg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= '0;
      busy_conv <= 1'b0;
      scan_addr <= '0;
      held_cfg <= '0;
      conv_cfg <= '0;
    end else begin
      if (latch_pins) begin
        held_cfg <= pin_cfg;
      end
      if (mode_edge) begin
        scan_addr <= '0;
      end else if (start_ok && mode == ACS_MODE_SCAN) begin
        scan_addr <= scan_addr + scan_step;
      end
      if (start_ok) begin
        busy_conv <= 1'b1;
        conv_cnt <= CONV_CNT[$bits(conv_cnt)-1:0];
        conv_cfg <= start_cfg;
      end else if (busy_conv) begin
        conv_cnt <= conv_cnt - 1'b1;
        busy_conv <= (conv_cnt != 1);
      end
    end
  end

  assign busy = ~(busy_conv | in_prog);
  assign conv_start_pulse = start_ok;

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  logic reading;
  logic [WORD_W-1:0] rd_word;
  logic [DATA_W-1:0] result_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reading <= 1'b0;
      rd_word <= '0;
      result_q <= '0;
    end else begin
      if (in_prog && rd_fall && s_wr) begin
        reading <= 1'b1;
        rd_word <= cur_word;
      end else if (rd_rise || !in_prog) begin
        reading <= 1'b0;
      end
      if (busy_conv && conv_cnt == 1) begin
        result_q <= conv_result;
      end
    end
  end

  wire [DATA_W-1:0] rb_data = {rd_word[STAT_HI:0],
    {LOW_PINS{1'b0}}};
  assign data_out = reading ? rb_data : result_q;
  assign data_oe = reading ? {{(DATA_W-LOW_PINS){1'b1}},
    {LOW_PINS{1'b0}}}
    : {DATA_W{~s_rd & ~s_cs}};
  assign addr_oe = reading | (~s_rd & ~s_cs);
  assign pair_indicator_out = reading ? rd_word[WORD_W-1]
    : conv_cfg[CFG_PAIR];
  assign channel_out_bits = reading ? rd_word[WORD_W-2:WORD_W-4]
    : conv_cfg[CFG_CH_HI:CFG_CH_LO];
  assign polarity_out = conv_cfg[CFG_POL];
  assign gain_out = conv_cfg[CFG_GAIN];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_PROG_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    in_prog |-> !busy) else $error("busy high in program mode");
  AST_NO_START_PROG: assert property (@(posedge clk) disable iff (!rst_n)
    in_prog |-> !conv_start_pulse)
    else $error("start taken in program mode");
  AST_MODE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    mode_edge |=> ptr == PTR_ZERO)
    else $error("pointer not cleared on mode edge");
  AST_WR_ADV: assert property (@(posedge clk) disable iff (!rst_n)
    do_write && !mode_edge |=> ptr == $past(ptr) + PTR_ONE)
    else $error("pointer not advanced by write");
  AST_WR_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    do_write |=> seq_mem[$past(ptr)] == $past(pin_cfg))
    else $error("entry not stored");
  AST_RD_OE: assert property (@(posedge clk) disable iff (!rst_n)
    reading |-> data_oe[LOW_PINS-1:0] == '0 && addr_oe)
    else $error("readback drive wrong");
  AST_RD_REL: assert property (@(posedge clk) disable iff (!rst_n)
    in_prog && rd_rise |=> !reading)
    else $error("outputs not released");
  AST_RUN_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    run_start && !mode_edge && ptr == last_ptr |=> ptr == PTR_ZERO)
    else $error("run did not wrap");
  AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    start_ok |=> busy_conv [*8])
    else $error("conversion ended early");
  AST_CONV_END: assert property (@(posedge clk) disable iff (!rst_n)
    start_ok |-> ##[1:700] !busy_conv)
    else $error("conversion never ended");
  AST_RUN_CFG: assert property (@(posedge clk) disable iff (!rst_n)
    run_start |=> conv_cfg == seq_mem[$past(ptr)])
    else $error("run used wrong entry");

  // ----------------------------------------
  // Readback checks
  // ----------------------------------------
  // The word is frozen at the read fall so a mode change cannot tear it
  AST_RD_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    in_prog && rd_fall && s_wr |=> reading && rd_word == $past(cur_word))
    else $error("readback word not presented");

  AST_RD_PINS: assert property (@(posedge clk) disable iff (!rst_n)
    reading |-> pair_indicator_out == rd_word[WORD_W-1]
    && channel_out_bits == rd_word[WORD_W-2:WORD_W-4]
    && data_out[DATA_W-1:LOW_PINS] == rd_word[STAT_HI:0])
    else $error("readback bits misplaced");

  AST_RD_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    in_prog && rd_fall && s_wr |=>
    rd_word[0] == ($past(ptr) == $past(last_ptr)))
    else $error("last entry flag wrong");

  AST_RD_ADV: assert property (@(posedge clk) disable iff (!rst_n)
    do_read_end && !mode_edge |=> ptr == $past(ptr) + PTR_ONE)
    else $error("pointer not advanced by read");

  AST_OE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !reading && s_rd |-> data_oe == '0 && !addr_oe)
    else $error("drivers enabled while idle");

  AST_LAST_SET: assert property (@(posedge clk) disable iff (!rst_n)
    mlo_rise && s_mhi && wrote_any |=> last_ptr == $past(wr_last))
    else $error("sequence end not taken");

  // Contents only move on a write strobe
  AST_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    !do_write |=> seq_mem[$past(ptr)] == $past(seq_mem[ptr]))
    else $error("entry changed without write");

  // ----------------------------------------
  // Conversion checks
  // ----------------------------------------
  AST_START_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    start_ok |=> !busy)
    else $error("busy not low after start");

  AST_NO_START_CS: assert property (@(posedge clk) disable iff (!rst_n)
    s_cs |-> !conv_start_pulse)
    else $error("start taken while deselected");

  AST_RUN_READY: assert property (@(posedge clk) disable iff (!rst_n)
    in_run && !busy_conv |-> busy)
    else $error("busy low while idle in run");

  AST_SCAN_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    start_ok && mode == ACS_MODE_SCAN && !mode_edge
    |=> scan_addr == $past(scan_addr) + $past(scan_step))
    else $error("scan address step wrong");

  // Latched setup wins while the write strobe stays high
  AST_DIRECT_CFG: assert property (@(posedge clk) disable iff (!rst_n)
    start_ok && mode == ACS_MODE_DIRECT && s_wr
    |=> conv_cfg == $past(held_cfg))
    else $error("direct mode used wrong setup");


  COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n) do_write);
  COV_READ: cover property (@(posedge clk) disable iff (!rst_n)
    reading ##1 !reading);
  COV_RUN_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
    run_start && ptr == last_ptr);
  COV_SCAN: cover property (@(posedge clk) disable iff (!rst_n)
    start_ok && mode == ACS_MODE_SCAN);
  COV_DIRECT: cover property (@(posedge clk) disable iff (!rst_n)
    start_ok && mode == ACS_MODE_DIRECT);
endmodule

// File: test/acs_host_model.sv
// Purpose: Host-side model that drives the mode pins and the strobes.
// Assumes: Pins change just after a clock rise.
// Notes: Each strobe level is held well past the 3-cycle sync minimum.
module acs_host_model (
  input wire logic clk,
  input wire logic pair_indicator_out,
  input wire logic [2:0] channel_out_bits,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe,
  input wire logic addr_oe,
  output logic mode_select_hi,
  output logic mode_select_lo,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic convert_start_n,
  output logic chip_select_n,
  output logic [5:0] cfg
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {mode_select_hi, mode_select_lo} = 2'h3;
    {write_strobe_n, read_strobe_n, convert_start_n} = 3'h7;
    chip_select_n = 1'h0;
    cfg = 6'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // A mode edge also zeroes the pointer before each pass
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    {mode_select_hi, mode_select_lo} <= m;
    hold(6);
  endtask
  // Read strobe stays high for the whole write
  task automatic write_entry(input logic [5:0] c);
    @(posedge clk);
    cfg <= c;
    write_strobe_n <= 1'h0;
    hold(5);
    write_strobe_n <= 1'h1;
    hold(5);
  endtask
  task automatic read_entry(output logic [6:0] w, output logic [11:0] oe,
    output logic ao, output logic [11:0] oe_off);
    @(posedge clk);
    read_strobe_n <= 1'h0;
    hold(6);
    w = {pair_indicator_out, channel_out_bits, data_out[11:9]};
    oe = data_oe;
    ao = addr_oe;
    read_strobe_n <= 1'h1;
    hold(6);
    oe_off = data_oe;
  endtask
  task automatic convert(input logic cs_n);
    @(posedge clk);
    chip_select_n <= cs_n;
    hold(3);
    convert_start_n <= 1'h0;
    hold(4);
    convert_start_n <= 1'h1;
    chip_select_n <= 1'h0;
    hold(1);
  endtask
endmodule

// File: test/adc_channel_sequencer_tb.sv
// Purpose: Self-checking bench for the channel sequencer.
// Assumes: Short conversion count of 10 cycles.
// Notes: Expected entries kept in a local copy of the sequence.
module adc_channel_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import acs_pkg::*;
  logic clk, resetn, busy, pair_indicator_out, polarity_out, gain_out;
  logic addr_oe, mode_select_hi, mode_select_lo, write_strobe_n;
  logic read_strobe_n, convert_start_n, chip_select_n, conv_start_pulse;
  int n_starts = 0;
  logic [2:0] channel_out_bits;
  logic [5:0] cfg;
  logic [11:0] data_out, data_oe, conv_result;
  logic [5:0] mem [16];
  int last, n_errors, tests_run;
  acs_sequencer #(.CONV_CNT(10)) u_acs_sequencer (.clk, .resetn,
    .mode_select_hi, .mode_select_lo, .write_strobe_n, .read_strobe_n,
    .convert_start_n, .chip_select_n, .pair_select(cfg[5]),
    .channel_select_bits(cfg[4:2]), .polarity_select(cfg[1]),
    .gain_select(cfg[0]), .conv_result, .busy, .pair_indicator_out,
    .channel_out_bits, .polarity_out, .gain_out, .conv_start_pulse,
    .data_out, .data_oe, .addr_oe);
  acs_host_model u_host (.clk, .pair_indicator_out, .channel_out_bits,
    .data_out, .data_oe, .addr_oe, .mode_select_hi, .mode_select_lo,
    .write_strobe_n, .read_strobe_n, .convert_start_n, .chip_select_n,
    .cfg);
  always @(posedge clk) if (conv_start_pulse === 1'b1) n_starts <= n_starts + 1;
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_check(input int i);
    logic [6:0] w;
    logic [11:0] oe, off;
    logic ao;
    u_host.read_entry(w, oe, ao, off);
    check(w, {mem[i], i == last});
    check(oe, 12'hE00);
    check(ao, 1'h1);
    check(off, 12'h000);
  endtask
  task automatic conv_check(input logic [5:0] e, input logic [11:0] r);
    int s0;
    s0 = n_starts;
    conv_result <= r;
    u_host.convert(1'h0);
    check(busy, 1'h0);
    for (int i = 0; i < 40 && busy !== 1'h1; i++) @(posedge clk);
    @(posedge clk);
    check(busy, 1'h1);
    check({pair_indicator_out, channel_out_bits, polarity_out, gain_out},
      e);
    check(data_out, r);
    check(12'(n_starts - s0), 12'h001);
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    resetn = 1'h0;
    conv_result = 12'h000;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    u_host.hold(4);
    check(busy, 1'h1);
    u_host.set_mode(ACS_MODE_PROG);
    check(busy, 1'h0);
    u_host.convert(1'h0);
    check(busy, 1'h0);
    mem[0] = 6'h2B;
    mem[1] = 6'h14;
    mem[2] = 6'h3E;
    last = 2;
    for (int i = 0; i < 3; i++) u_host.write_entry(mem[i]);
    u_host.set_mode(ACS_MODE_RUN);
    check(busy, 1'h1);
    u_host.set_mode(ACS_MODE_PROG);
    for (int i = 0; i < 3; i++) rd_check(i);
    u_host.set_mode(ACS_MODE_RUN);
    for (int k = 0; k < 4; k++) conv_check(mem[k % 3], 12'h1A0 + k);
    u_host.convert(1'h1);
    check(busy, 1'h1);
    conv_check(mem[1], 12'hC35);
    u_host.set_mode(ACS_MODE_PROG);
    for (int i = 0; i < 17; i++) begin
      mem[i % 16] = 6'(i) ^ 6'h15;
      u_host.write_entry(mem[i % 16]);
    end
    last = 0;
    u_host.set_mode(ACS_MODE_RUN);
    u_host.set_mode(ACS_MODE_PROG);
    for (int i = 0; i < 17; i++) rd_check(i % 16);
    u_host.set_mode(ACS_MODE_DIRECT);
    u_host.write_entry(6'h1B);
    conv_check(6'h1B, 12'h7E1);
    u_host.set_mode(ACS_MODE_SCAN);
    u_host.write_entry(6'h03);
    conv_check(6'h03, 12'h222);
    conv_check(6'h07, 12'h333);
    u_host.set_mode(ACS_MODE_RUN);
    conv_check(mem[0], 12'h444);
    conv_check(mem[0], 12'h555);
    report_and_stop();
  end
  // Whole run is near 800 cycles; this limit leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
